// [hw/bcp_pkg.sv]
// constants shared by the board control port block
package bcp_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] OFF_GEN_CTRL = 8'h00;
  localparam logic [7:0] OFF_PB_CTRL = 8'h04;
  localparam logic [7:0] OFF_PB_DATA = 8'h08;
  localparam logic [7:0] OFF_PB_DIR = 8'h0c;
  localparam logic [7:0] OFF_PA_DATA = 8'h10;
  localparam logic [7:0] OFF_PA_DIR = 8'h14;
  localparam logic [7:0] OFF_PC_DATA = 8'h18;
  localparam logic [7:0] OFF_PC_DIR = 8'h1c;
  localparam logic [7:0] OFF_TMR_CTRL = 8'h20;
  localparam logic [7:0] OFF_TMR_PRELOAD = 8'h24;
  localparam logic [7:0] OFF_TMR_COUNT = 8'h28;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h34;
  // general control and port b control fields
  localparam int GEN_MODE_HI = 7;
  localparam int GEN_MODE_LO = 6;
  localparam int PB_SUBMODE_BIT = 7;
  // board control port bits
  localparam int B_ARB = 7;
  localparam int B_ROLE_N = 6;
  localparam int B_RQ_HI = 5;
  localparam int B_RQ_LO = 4;
  localparam int B_SCL = 3;
  localparam int B_SDA = 2;
  localparam int B_CHA = 1;
  // third port bits
  localparam int PC_PA_EN_N = 0;
  localparam int PC_PA_DIR = 1;
  localparam int PC_WATCHDOG_REFRESH = 4;
  // timer control bits
  localparam int TC_EN = 0;
  localparam int TC_PERIODIC = 1;
  localparam int TC_SRC_RTC = 2;
  localparam int TC_PRESCALE = 3;
  // interrupt status and mask bits
  localparam int IRQ_TMR = 0;
  localparam int IRQ_RTC = 1;
  localparam int IRQ_W = 2;
  // reset values
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PB_DATA = 8'h40;
  localparam logic [7:0] RST_PC_DATA = 8'h01;
  // timer geometry and clock divider
  localparam int TMR_W = 24;
  localparam int PRESCALE_W = 5;
  localparam int CLK_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);
  localparam logic [PRESCALE_W-1:0] PRE_LAST = 5'h1f;
  // synchroniser lanes
  localparam int SY_PA = 0;
  localparam int SY_SDA = 8;
  localparam int SY_RTC = 9;
  localparam int SY_XTAL = 10;
  localparam int SY_EXT = 11;
  localparam int SY_LINK = 12;
  localparam int SYNC_W = 13;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : bcp_pkg

// [hw/bcp_tmr_if.sv]
// carrier between the register block and the interval timer
`timescale 1ns/1ps
interface bcp_tmr_if;
  logic enable;
  logic periodic;
  logic src_rtc;
  logic prescale_en;
  logic [bcp_pkg::TMR_W-1:0] preload;
  logic load;
  logic rtc_level;
  logic [bcp_pkg::TMR_W-1:0] count;
  logic expired;
  logic div_clk;
  modport ctl (output enable, periodic, src_rtc, prescale_en, preload, load, rtc_level,
               input count, expired, div_clk);
  modport tmr (input enable, periodic, src_rtc, prescale_en, preload, load, rtc_level,
               output count, expired, div_clk);
endinterface : bcp_tmr_if

// [hw/bcp_timer.sv]
// 24-bit interval timer with prescaler and divided clock
`timescale 1ns/1ps
module bcp_timer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and status
  bcp_tmr_if.tmr tif
);
  typedef struct packed {
    logic [1:0] div;
    logic div_clk;
    logic rtc_prev;
    logic [bcp_pkg::PRESCALE_W-1:0] pre;
    logic [bcp_pkg::TMR_W-1:0] count;
    logic running;
    logic expired;
  } bcp_tmr_state_s;

  bcp_tmr_state_s q;
  bcp_tmr_state_s d;
  logic src_tick;
  logic cnt_tick;

  always_comb begin
    d = q;
    d.expired = 1'b0;
    d.div = q.div + 2'h1;
    d.div_clk = q.div[1];
    d.rtc_prev = tif.rtc_level;
    src_tick = tif.src_rtc ? (tif.rtc_level & ~q.rtc_prev) : (q.div == bcp_pkg::DIV_LAST);
    cnt_tick = 1'b0;
    if (src_tick) begin
      if (tif.prescale_en) begin
        d.pre = q.pre + 5'h01;
        cnt_tick = (q.pre == bcp_pkg::PRE_LAST);
      end else begin
        cnt_tick = 1'b1;
      end
    end
    if (tif.load) begin
      d.count = tif.preload;
      d.running = tif.enable;
      d.pre = '0;
    end else if (cnt_tick && tif.enable && q.running) begin
      if (q.count == '0) begin
        d.expired = 1'b1;
        if (tif.periodic) begin
          d.count = tif.preload;
        end else begin
          d.running = 1'b0;
        end
      end else begin
        d.count = q.count - 24'h000001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tif.count = q.count;
  assign tif.expired = q.expired;
  assign tif.div_clk = q.div_clk;
endmodule : bcp_timer

// [hw/bcp_board_ctrl.sv]
// board control port, transceiver port, timer and register slave
`timescale 1ns/1ps
module bcp_board_ctrl #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus arbitration and role
  input wire logic sys_controller_link_override,
  output logic arbitration_scheme_select,
  output logic bus_controller_role_n,
  output logic priority_arbiter_en,
  output logic round_robin_arbiter_en,
  output logic sysclk_bclr_drive_en,
  output logic bus_request_level_hi,
  output logic bus_request_level_lo,
  // serial eeprom
  output logic eeprom_scl,
  input wire logic eeprom_sda_i,
  output logic eeprom_sda_o,
  output logic eeprom_sda_oe_n,
  // serial channel a clock
  input wire logic chan_a_crystal_clock,
  input wire logic chan_a_external_clock,
  output logic chan_a_clock_select,
  output logic chan_a_serial_clock_pin,
  // transceiver buffered port
  input wire logic [7:0] port_a_i,
  output logic [7:0] port_a_o,
  output logic [7:0] port_a_oe_n,
  output logic port_a_transceiver_direction,
  output logic port_a_transceiver_enable_n,
  // watchdog and timer
  output logic watchdog_refresh_o,
  output logic watchdog_refresh_oe_n,
  input wire logic rtc_timer1_output,
  output logic parallel_timer_unit_clk,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [bcp_pkg::SYNC_W-1:0] s1;
    logic [bcp_pkg::SYNC_W-1:0] s2;
    logic [bcp_pkg::SYNC_W-1:0] s3;
    logic [bcp_pkg::SYNC_W-1:0] pins;
    logic aw_have;
    logic [ADDR_W-1:0] awa;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] gen_ctrl;
    logic [7:0] pb_ctrl;
    logic [7:0] pb_data;
    logic [7:0] pb_dir;
    logic [7:0] pb_pins;
    logic [7:0] pa_data;
    logic [7:0] pa_dir;
    logic [7:0] pc_data;
    logic [7:0] pc_dir;
    logic [3:0] tmr_ctrl;
    logic [bcp_pkg::TMR_W-1:0] preload;
    logic tmr_load;
    logic rtc_prev;
    logic [bcp_pkg::IRQ_W-1:0] irq_status;
    logic [bcp_pkg::IRQ_W-1:0] irq_mask;
    logic controller;
    logic chan_a_clk;
    logic irq;
  } bcp_state_s;

  bcp_state_s q;
  bcp_state_s d;
  bcp_tmr_if tif ();
  logic port_active;
  logic [7:0] pb_read;
  logic [7:0] pa_read;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [bcp_pkg::SYNC_W-1:0] raw_pins;

  bcp_timer u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .tif(tif)
  );

  assign raw_pins = {sys_controller_link_override, chan_a_external_clock, chan_a_crystal_clock,
                     rtc_timer1_output, eeprom_sda_i, port_a_i};
  assign tif.enable = q.tmr_ctrl[bcp_pkg::TC_EN];
  assign tif.periodic = q.tmr_ctrl[bcp_pkg::TC_PERIODIC];
  assign tif.src_rtc = q.tmr_ctrl[bcp_pkg::TC_SRC_RTC];
  assign tif.prescale_en = q.tmr_ctrl[bcp_pkg::TC_PRESCALE];
  assign tif.preload = q.preload;
  assign tif.load = q.tmr_load;
  assign tif.rtc_level = q.pins[bcp_pkg::SY_RTC];

  always_comb begin
    d = q;
    d.tmr_load = 1'b0;
    // pins pass three flops; a lane moves only when the last two agree
    d.s1 = raw_pins;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < bcp_pkg::SYNC_W; i++) begin
      if (q.s2[i] == q.s3[i]) begin
        d.pins[i] = q.s3[i];
      end
    end
    // the port only follows software once the unit is in plain bit i/o
    port_active = (q.gen_ctrl[bcp_pkg::GEN_MODE_HI:bcp_pkg::GEN_MODE_LO] == 2'h0)
                  && q.pb_ctrl[bcp_pkg::PB_SUBMODE_BIT];
    pb_read = q.pb_pins;
    if (!q.pb_dir[bcp_pkg::B_SDA]) begin
      pb_read[bcp_pkg::B_SDA] = q.pins[bcp_pkg::SY_SDA];
    end
    pa_read = (q.pa_data & q.pa_dir) | (q.pins[bcp_pkg::SY_PA +: 8] & ~q.pa_dir);
    // write channel: address and data may arrive in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    wa = {d.awa[7:2], 2'h0};
    if (d.aw_have && d.w_have && !d.bvalid) begin
      d.aw_have = 1'b0;
      d.w_have = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = bcp_pkg::RESP_OKAY;
      case (wa)
        bcp_pkg::OFF_GEN_CTRL: if (d.wstrb[0]) d.gen_ctrl = d.wdata[7:0];
        bcp_pkg::OFF_PB_CTRL: if (d.wstrb[0]) d.pb_ctrl = d.wdata[7:0];
        bcp_pkg::OFF_PB_DATA: if (d.wstrb[0]) d.pb_data = d.wdata[7:0];
        bcp_pkg::OFF_PB_DIR: if (d.wstrb[0]) d.pb_dir = d.wdata[7:0];
        bcp_pkg::OFF_PA_DATA: if (d.wstrb[0]) d.pa_data = d.wdata[7:0];
        bcp_pkg::OFF_PA_DIR: if (d.wstrb[0]) d.pa_dir = d.wdata[7:0];
        bcp_pkg::OFF_PC_DATA: if (d.wstrb[0]) d.pc_data = d.wdata[7:0];
        bcp_pkg::OFF_PC_DIR: if (d.wstrb[0]) d.pc_dir = d.wdata[7:0];
        bcp_pkg::OFF_TMR_CTRL: begin
          if (d.wstrb[0]) begin
            d.tmr_ctrl = d.wdata[3:0];
            d.tmr_load = 1'b1;
          end
        end
        bcp_pkg::OFF_TMR_PRELOAD: begin
          for (int b = 0; b < 3; b++) begin
            if (d.wstrb[b]) begin
              d.preload[b*8 +: 8] = d.wdata[b*8 +: 8];
            end
          end
        end
        bcp_pkg::OFF_TMR_COUNT: d.bresp = bcp_pkg::RESP_OKAY;
        bcp_pkg::OFF_IRQ_STATUS: begin
          if (d.wstrb[0]) begin
            d.irq_status = q.irq_status & ~d.wdata[bcp_pkg::IRQ_W-1:0];
          end
        end
        bcp_pkg::OFF_IRQ_MASK: if (d.wstrb[0]) d.irq_mask = d.wdata[bcp_pkg::IRQ_W-1:0];
        default: d.bresp = bcp_pkg::RESP_SLVERR;
      endcase
    end
    d.awready = ~d.aw_have & ~d.bvalid;
    d.wready = ~d.w_have & ~d.bvalid;
    // read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    ra = {s_axi_araddr[7:2], 2'h0};
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = bcp_pkg::RESP_OKAY;
      d.rdata = 32'h0000_0000;
      case (ra)
        bcp_pkg::OFF_GEN_CTRL: d.rdata[7:0] = q.gen_ctrl;
        bcp_pkg::OFF_PB_CTRL: d.rdata[7:0] = q.pb_ctrl;
        bcp_pkg::OFF_PB_DATA: d.rdata[7:0] = pb_read;
        bcp_pkg::OFF_PB_DIR: d.rdata[7:0] = q.pb_dir;
        bcp_pkg::OFF_PA_DATA: d.rdata[7:0] = pa_read;
        bcp_pkg::OFF_PA_DIR: d.rdata[7:0] = q.pa_dir;
        bcp_pkg::OFF_PC_DATA: d.rdata[7:0] = q.pc_data;
        bcp_pkg::OFF_PC_DIR: d.rdata[7:0] = q.pc_dir;
        bcp_pkg::OFF_TMR_CTRL: d.rdata[3:0] = q.tmr_ctrl;
        bcp_pkg::OFF_TMR_PRELOAD: d.rdata[bcp_pkg::TMR_W-1:0] = q.preload;
        bcp_pkg::OFF_TMR_COUNT: d.rdata[bcp_pkg::TMR_W-1:0] = tif.count;
        bcp_pkg::OFF_IRQ_STATUS: d.rdata[bcp_pkg::IRQ_W-1:0] = q.irq_status;
        bcp_pkg::OFF_IRQ_MASK: d.rdata[bcp_pkg::IRQ_W-1:0] = q.irq_mask;
        default: d.rresp = bcp_pkg::RESP_SLVERR;
      endcase
    end
    d.arready = ~d.rvalid;
    // output bits change only when written and configured as outputs
    for (int i = 0; i < 8; i++) begin
      if (port_active && q.pb_dir[i]) begin
        d.pb_pins[i] = q.pb_data[i];
      end
    end
    // the link forces non-controller regardless of software
    d.controller = ~q.pb_pins[bcp_pkg::B_ROLE_N] & ~q.pins[bcp_pkg::SY_LINK];
    // resampled at aclk: up to one aclk period of edge jitter on the serial clock
    d.chan_a_clk = q.pb_pins[bcp_pkg::B_CHA] ? q.pins[bcp_pkg::SY_EXT]
                                             : q.pins[bcp_pkg::SY_XTAL];
    // events: a set in the clearing cycle wins
    d.rtc_prev = q.pins[bcp_pkg::SY_RTC];
    if (tif.expired) begin
      d.irq_status[bcp_pkg::IRQ_TMR] = 1'b1;
    end
    if (q.pins[bcp_pkg::SY_RTC] && !q.rtc_prev) begin
      d.irq_status[bcp_pkg::IRQ_RTC] = 1'b1;
    end
    d.irq = |(d.irq_status & d.irq_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.pb_data <= bcp_pkg::RST_PB_DATA;
      q.pb_pins <= bcp_pkg::RST_PB_DATA;
      q.pc_data <= bcp_pkg::RST_PC_DATA;
      q.gen_ctrl <= bcp_pkg::RST_ZERO;
      q.pb_dir <= bcp_pkg::RST_ZERO;
    end else begin
      q <= d;
    end
  end

  // bus
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;
  // board control pins
  assign arbitration_scheme_select = q.pb_pins[bcp_pkg::B_ARB];
  assign bus_controller_role_n = ~q.controller;
  assign priority_arbiter_en = q.controller & q.pb_pins[bcp_pkg::B_ARB];
  assign round_robin_arbiter_en = q.controller & ~q.pb_pins[bcp_pkg::B_ARB];
  assign sysclk_bclr_drive_en = q.controller;
  assign bus_request_level_hi = q.pb_pins[bcp_pkg::B_RQ_HI];
  assign bus_request_level_lo = q.pb_pins[bcp_pkg::B_RQ_LO];
  assign eeprom_scl = q.pb_pins[bcp_pkg::B_SCL];
  assign eeprom_sda_o = q.pb_pins[bcp_pkg::B_SDA];
  assign eeprom_sda_oe_n = ~q.pb_dir[bcp_pkg::B_SDA];
  assign chan_a_clock_select = q.pb_pins[bcp_pkg::B_CHA];
  assign chan_a_serial_clock_pin = q.chan_a_clk;
  // transceiver port
  assign port_a_o = q.pa_data;
  assign port_a_oe_n = ~q.pa_dir;
  assign port_a_transceiver_direction = q.pc_data[bcp_pkg::PC_PA_DIR];
  assign port_a_transceiver_enable_n = q.pc_data[bcp_pkg::PC_PA_EN_N];
  // watchdog pin as input disables the watchdog
  assign watchdog_refresh_o = q.pc_data[bcp_pkg::PC_WATCHDOG_REFRESH];
  assign watchdog_refresh_oe_n = ~q.pc_dir[bcp_pkg::PC_WATCHDOG_REFRESH];
  assign parallel_timer_unit_clk = tif.div_clk;
  assign irq = q.irq;
endmodule : bcp_board_ctrl

// [dv/bcp_board_ctrl_monitor.sv]
// concurrent checks on the board control port pins and register bus
`timescale 1ns/1ps
module bcp_board_ctrl_monitor (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // arbitration
  input wire logic sys_controller_link_override,
  input wire logic priority_arbiter_en,
  input wire logic round_robin_arbiter_en,
  input wire logic sysclk_bclr_drive_en,
  // clocks
  input wire logic chan_a_crystal_clock,
  input wire logic chan_a_external_clock,
  input wire logic chan_a_clock_select,
  input wire logic chan_a_serial_clock_pin,
  input wire logic parallel_timer_unit_clk
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("no write answer");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("no read answer");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  arb_excl_a: assert property (!(priority_arbiter_en && round_robin_arbiter_en))
    else $error("both arbiters on");
  ctrl_drive_a: assert property ((priority_arbiter_en || round_robin_arbiter_en) == sysclk_bclr_drive_en)
    else $error("arbiter and bus drive disagree");
  link_force_a: assert property (sys_controller_link_override [*8] |-> !sysclk_bclr_drive_en)
    else $error("link override ignored");
  clk_div_a: assert property ($rose(parallel_timer_unit_clk) |=>
    parallel_timer_unit_clk ##1 !parallel_timer_unit_clk [*2] ##1 parallel_timer_unit_clk)
    else $error("timer clock not a quarter rate");
  xtal_pick_a: assert property ((!chan_a_clock_select && chan_a_crystal_clock) [*8] |->
    chan_a_serial_clock_pin)
    else $error("crystal not routed");
  ext_pick_a: assert property ((chan_a_clock_select && !chan_a_external_clock) [*8] |->
    !chan_a_serial_clock_pin)
    else $error("external clock not routed");
endmodule : bcp_board_ctrl_monitor
bind bcp_board_ctrl bcp_board_ctrl_monitor bcp_board_ctrl_monitor_inst (.*);

// [dv/bcp_far_model.sv]
// eeprom line, transceiver and serial clock sources around the block
`timescale 1ns/1ps
module bcp_far_model (
  // eeprom
  input wire logic eeprom_sda_o,
  input wire logic eeprom_sda_oe_n,
  input wire logic eeprom_pull_low,
  output logic eeprom_sda_i,
  // transceiver
  input wire logic aclk,
  input wire logic [7:0] port_a_o,
  input wire logic [7:0] port_a_oe_n,
  input wire logic port_a_transceiver_direction,
  input wire logic port_a_transceiver_enable_n,
  input wire logic [7:0] connector_value,
  output logic [7:0] port_a_i,
  output logic [7:0] connector_seen,
  // serial clocks
  output logic chan_a_crystal_clock,
  output logic chan_a_external_clock
);
  logic [7:0] churn_q = 8'h5a;
  // floating connector lines churn so a stale value never reads as valid
  always @(posedge aclk) churn_q <= churn_q + 8'h3b;
  // pulled up; either party may pull low
  assign eeprom_sda_i = (eeprom_sda_oe_n | eeprom_sda_o) & !eeprom_pull_low;
  // a disabled transceiver lets the port float: show the inverse of what the port drives
  assign port_a_i = port_a_transceiver_enable_n ? ~port_a_o :
    port_a_transceiver_direction ? port_a_o : connector_value;
  assign connector_seen = (port_a_transceiver_enable_n || !port_a_transceiver_direction) ? ~churn_q : port_a_o;
  initial begin
    chan_a_crystal_clock = 1'b0;
    chan_a_external_clock = 1'b0;
  end
  always #67.817 chan_a_crystal_clock = !chan_a_crystal_clock;
  always #100 chan_a_external_clock = !chan_a_external_clock;
endmodule : bcp_far_model

// [dv/bcp_tb.sv]
// self-checking bench for the board control port block
`timescale 1ns/1ps
module testbench;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, connector_value = 8'h00, pins = 8'h40, d;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd, lf = 32'h02ffd458;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic sys_controller_link_override = 1'b0, rtc_timer1_output = 1'b0, eeprom_pull_low = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, priority_arbiter_en;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic arbitration_scheme_select, bus_controller_role_n, round_robin_arbiter_en, sysclk_bclr_drive_en;
  logic bus_request_level_hi, bus_request_level_lo, eeprom_scl, eeprom_sda_i, eeprom_sda_o, eeprom_sda_oe_n;
  logic chan_a_crystal_clock, chan_a_external_clock, chan_a_clock_select, chan_a_serial_clock_pin, irq;
  logic port_a_transceiver_direction, port_a_transceiver_enable_n, watchdog_refresh_o, watchdog_refresh_oe_n;
  logic parallel_timer_unit_clk, c;
  logic [7:0] port_a_i, port_a_o, port_a_oe_n, connector_seen;
  logic [31:0] mdl [0:15];
  int fails = 0, check_count = 0, n, i;
  always #4 aclk = !aclk;
  bcp_board_ctrl bcp_board_ctrl_inst (.*);
  bcp_far_model bcp_far_model_inst (.*);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] exp_rd(input logic [7:0] a);
    if (a == bcp_pkg::OFF_PB_DATA) return {24'h0, pins[7:3], mdl[3][2] ? pins[2] : !eeprom_pull_low, pins[1:0]};
    if (a == bcp_pkg::OFF_PA_DATA) return {24'h0, (mdl[4][7:0] & mdl[5][7:0]) | (~mdl[5][7:0] &
      (mdl[6][0] ? ~mdl[4][7:0] : (mdl[6][1] ? mdl[4][7:0] : connector_value)))};
    return mdl[a[5:2]];
  endfunction : exp_rd
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  task automatic guard(input int lim);
    if (n >= lim) begin
      chk("wait bound", 0, n);
      stop_test();
    end
  endtask : guard
  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] resp = 2'h0);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    guard(50);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk("bresp", resp, s_axi_bresp);
    // status bits are write-one-to-clear
    if (a == bcp_pkg::OFF_IRQ_STATUS) mdl[12] = mdl[12] & ~v;
    else if (resp == 2'h0) mdl[a[5:2]] = v & (a == bcp_pkg::OFF_TMR_PRELOAD ? 32'hffffff : 32'hff);
    // output pins follow the data register whenever the port is in plain bit i/o
    if (mdl[0][7:6] == 2'b00 && mdl[1][7]) pins = (pins & ~mdl[3][7:0]) | (mdl[2][7:0] & mdl[3][7:0]);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [1:0] resp = 2'h0);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    guard(50);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk("rresp", resp, s_axi_rresp);
    chk("rdata", resp == 2'h0 ? exp_rd(a) : 32'h0, s_axi_rdata);
  endtask : rdc
  task automatic pin_chk();
    c = !pins[6] && !sys_controller_link_override;
    chk("board pins", {pins[7], pins[6] | sys_controller_link_override, pins[5:3], pins[1]}, {arbitration_scheme_select,
      bus_controller_role_n | sys_controller_link_override, bus_request_level_hi, bus_request_level_lo, eeprom_scl, chan_a_clock_select});
    chk("arbiter", {c & pins[7], c & !pins[7], c}, {priority_arbiter_en, round_robin_arbiter_en, sysclk_bclr_drive_en});
    chk("sda drive", {!mdl[3][2], pins[2] | !mdl[3][2]}, {eeprom_sda_oe_n, eeprom_sda_o | eeprom_sda_oe_n});
  endtask : pin_chk
  task automatic wait_irq(input int lim);
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge aclk);
      n++;
    end
    guard(lim);
  endtask : wait_irq
  task automatic rtc_pulse();
    rtc_timer1_output <= 1'b1;
    tick(6);
    rtc_timer1_output <= 1'b0;
    tick(6);
  endtask : rtc_pulse
  initial begin
    foreach (mdl[k]) mdl[k] = 32'h0;
    mdl[2] = 32'h40;
    mdl[6] = 32'h01;
    tick(4);
    aresetn <= 1'b1;
    tick(2);
    pin_chk();
    chk("reset pins", 11'h6ff, {port_a_transceiver_enable_n, watchdog_refresh_oe_n, irq, port_a_oe_n});
    for (i = 0; i < 10; i++) rdc(8'(i * 4));
    for (i = 0; i < 3; i++) rdc(i == 0 ? 8'h2c : 8'(8'h34 + i * 4), 2'h2);
    wr(8'h3c, 32'h5a, 2'h2);
    $display("test reset and map finished");
    wr(bcp_pkg::OFF_GEN_CTRL, 32'h00);
    wr(bcp_pkg::OFF_PB_CTRL, 32'h80);
    wr(bcp_pkg::OFF_PB_DIR, 32'hfb);
    for (i = 0; i < 8; i++) begin
      lf = lfsr(lf);
      wr(bcp_pkg::OFF_PB_DATA, {24'h0, lf[7:6], 2'(i), lf[3:0]});
      tick(2);
      pin_chk();
      rdc(bcp_pkg::OFF_PB_DATA);
    end
    for (i = 0; i < 2; i++) begin
      wr(bcp_pkg::OFF_GEN_CTRL, i ? 32'h00 : 32'hc0);
      wr(bcp_pkg::OFF_PB_CTRL, i ? 32'h00 : 32'h80);
      wr(bcp_pkg::OFF_PB_DATA, {24'h0, ~pins});
      tick(2);
      pin_chk();
    end
    wr(bcp_pkg::OFF_GEN_CTRL, 32'h00);
    wr(bcp_pkg::OFF_PB_CTRL, 32'h80);
    for (i = 0; i < 4; i++) begin
      sys_controller_link_override <= i[1];
      wr(bcp_pkg::OFF_PB_DATA, {24'h0, i[0], 7'h00});
      tick(8);
      pin_chk();
    end
    $display("test board port finished");
    wr(bcp_pkg::OFF_PB_DIR, 32'hff);
    wr(bcp_pkg::OFF_PB_DATA, 32'h00);
    tick(2);
    pin_chk();
    wr(bcp_pkg::OFF_PB_DIR, 32'hfb);
    for (i = 0; i < 2; i++) begin
      eeprom_pull_low <= !i[0];
      tick(8);
      rdc(bcp_pkg::OFF_PB_DATA);
    end
    wr(bcp_pkg::OFF_PC_DIR, 32'h13);
    wr(bcp_pkg::OFF_PA_DIR, 32'hff);
    lf = lfsr(lf);
    d = lf[7:0];
    for (i = 0; i < 2; i++) begin
      wr(bcp_pkg::OFF_PC_DATA, {27'h0, i[0], 4'h2});
      wr(bcp_pkg::OFF_PA_DATA, {24'h0, d});
      tick(2);
      chk("watchdog", {i[0], 1'b0}, {watchdog_refresh_o, watchdog_refresh_oe_n});
      chk("outward", {2'b10, 8'h00, d}, {port_a_transceiver_direction, port_a_transceiver_enable_n, port_a_oe_n, connector_seen});
    end
    wr(bcp_pkg::OFF_PA_DIR, 32'h00);
    wr(bcp_pkg::OFF_PC_DATA, 32'h00);
    tick(2);
    chk("inward", {2'b00, 8'hff}, {port_a_transceiver_direction, port_a_transceiver_enable_n, port_a_oe_n});
    wr(bcp_pkg::OFF_PC_DATA, 32'h01);
    tick(2);
    chk("tri-state", 1'b1, port_a_transceiver_enable_n);
    $display("test eeprom and transceiver finished");
    wr(bcp_pkg::OFF_IRQ_MASK, 32'h1);
    for (i = 0; i < 3; i++) begin
      wr(bcp_pkg::OFF_TMR_PRELOAD, i == 2 ? 32'h1 : 32'h3);
      wr(bcp_pkg::OFF_TMR_CTRL, i == 2 ? 32'h9 : 32'(1 + 2 * i));
      wait_irq(400);
      if (i == 2) chk("prescaled delay", 1, n >= 120 && n <= 280);
      else chk("timer delay", 1, n >= 8 && n <= 26);
      mdl[12] = 32'h1;
      rdc(bcp_pkg::OFF_IRQ_STATUS);
      wr(bcp_pkg::OFF_IRQ_STATUS, 32'h1);
      if (i == 1) begin
        wait_irq(30);
        wr(bcp_pkg::OFF_TMR_CTRL, 32'h0);
        wr(bcp_pkg::OFF_IRQ_STATUS, 32'h1);
      end
      tick(40);
      chk("irq after clear", 1'b0, irq);
    end
    wr(bcp_pkg::OFF_IRQ_MASK, 32'h0);
    wr(bcp_pkg::OFF_TMR_CTRL, 32'h5);
    for (i = 2; i < 4; i++) begin
      rtc_pulse();
      mdl[12] = i;
      rdc(bcp_pkg::OFF_IRQ_STATUS);
      chk("masked irq", 1'b0, irq);
    end
    wr(bcp_pkg::OFF_IRQ_MASK, 32'h3);
    tick(2);
    chk("unmasked irq", 1'b1, irq);
    wr(bcp_pkg::OFF_IRQ_STATUS, 32'h3);
    mdl[12] = 0;
    tick(2);
    chk("cleared irq", 1'b0, irq);
    rdc(bcp_pkg::OFF_IRQ_STATUS);
    $display("test timer and interrupt finished");
    stop_test();
  end
endmodule : testbench
